/* rtl/ddr_sram_top.sv */
// burst-of-two double data rate sram device interface
// assumes the input clock pair is slow against clock (edges >= 2 clocks apart)
`timescale 1ns/10ps
`include "sram_consts.svh"

module ddr_sram_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic ld_n,
    input wire logic rw,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`WORD_W-1:0] dq_in,
    input wire logic pll_bypass_pin,
    output logic [`WORD_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic cq,
    output logic cq_n,
    output logic read_valid_flag,
    output logic wr_ready
);
    import sram_pkg::*;

    localparam int DRAIN_MAX = 3;
    localparam int ECHO_MAX = 1;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] k_s1_r;
    logic [1:0] k_s2_r;
    logic [1:0] k_s3_r;
    pin_in_t pin_s1_r;
    pin_in_t pin_s2_r;
    logic byp_s1_r;
    logic byp_s2_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            k_s1_r <= 2'h0;
            k_s2_r <= 2'h0;
            k_s3_r <= 2'h0;
        end else begin
            k_s1_r <= {k_clk_n, k_clk};
            k_s2_r <= k_s1_r;
            k_s3_r <= k_s2_r;
        end
    end

    // input register stage for every synchronous pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= '{ld_n: 1'b1, default: '0};
            pin_s2_r <= '{ld_n: 1'b1, default: '0};
            byp_s1_r <= 1'b0;
            byp_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= '{ld_n: ld_n, rw: rw, addr: addr, dq: dq_in};
            pin_s2_r <= pin_s1_r;
            byp_s1_r <= pll_bypass_pin;
            byp_s2_r <= byp_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edges and command capture

    wire k_rise = k_s2_r[0] & ~k_s3_r[0];
    wire k_n_rise = k_s2_r[1] & ~k_s3_r[1];
    wire any_edge = k_rise | k_n_rise;

    logic second_r;
    wire cmd_take = k_rise & ~second_r & ~pin_s2_r.ld_n;
    wire rd_take = cmd_take & pin_s2_r.rw;
    wire wr_take = cmd_take & ~pin_s2_r.rw;
    wire [2:0] lat = byp_s2_r ? `LAT_PLL_EDGES : `LAT_DLL_EDGES;

    // a taken address owns the next true rise as its second half
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            second_r <= 1'b0;
        end else if (k_rise) begin
            second_r <= cmd_take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write burst assembly

    logic wr_pend_r;
    logic wr_half_r;
    logic [`ADDR_W-1:0] wr_addr_r;
    logic [`WORD_W-1:0] wr_lo_r;

    wire lo_take = k_n_rise & wr_pend_r & ~wr_half_r;
    wire wr_push = k_rise & wr_half_r;
    wr_burst_t push_burst;
    wr_burst_t pop_burst;
    logic pop_valid;

    // word 0 on the complementary rise, word 1 on the next true rise
    assign push_burst = '{addr: wr_addr_r, data: {pin_s2_r.dq, wr_lo_r}};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_half_r <= 1'b0;
            wr_addr_r <= '0;
            wr_lo_r <= '0;
        end else if (wr_take) begin
            wr_pend_r <= 1'b1;
            wr_half_r <= 1'b0;
            wr_addr_r <= pin_s2_r.addr;
        end else if (lo_take) begin
            wr_half_r <= 1'b1;
            wr_lo_r <= pin_s2_r.dq;
        end else if (wr_push) begin
            wr_pend_r <= 1'b0;
            wr_half_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // posted write buffer and self-timed array writes

    wire drain = pop_valid & ~rd_take;
    logic [`BURST_W-1:0] mem_q;

    burst_fifo #(
        .W($bits(wr_burst_t)),
        .D(`FIFO_D)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_data(push_burst),
        .in_valid(wr_push),
        .in_ready(wr_ready),
        .out_data(pop_burst),
        .out_valid(pop_valid),
        .out_ready(drain)
    );

    burst_mem #(
        .AW(`ADDR_W),
        .DW(`BURST_W)
    ) u_mem (
        .clock(clock),
        .we(drain),
        .waddr(pop_burst.addr),
        .wdata(pop_burst.data),
        .re(rd_take),
        .raddr(pin_s2_r.addr),
        .rdata(mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read pipeline, one stage per input clock edge

    logic [`PIPE_D-1:0] pipe_v_r;
    logic [`BURST_W-1:0] pipe_d_r [`PIPE_D];
    logic rd_fill_r;

    wire [`PIPE_D-1:0] sh_v = {pipe_v_r[`PIPE_D-2:0], rd_take};
    wire lo_hit = sh_v[lat];
    wire hi_hit = sh_v[lat + 3'h1];
    wire [`BURST_W-1:0] lo_src = pipe_d_r[lat - 3'h1];
    wire [`BURST_W-1:0] hi_src = pipe_d_r[lat];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pipe_v_r <= '0;
            rd_fill_r <= 1'b0;
        end else begin
            rd_fill_r <= rd_take;
            if (any_edge) begin
                pipe_v_r <= sh_v;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (any_edge) begin
            for (int i = `PIPE_D-1; i > 0; i--) begin
                pipe_d_r[i] <= pipe_d_r[i-1];
            end
        end else if (rd_fill_r) begin
            pipe_d_r[0] <= mem_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output register stage, echo clocks

    logic valid_r;
    logic [`WORD_W-1:0] dq_r;
    logic cq_r;
    logic cq_n_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            dq_r <= '0;
        end else if (any_edge) begin
            valid_r <= lo_hit | hi_hit;
            if (lo_hit) begin
                dq_r <= lo_src[`WORD_W-1:0];
            end else if (hi_hit) begin
                dq_r <= hi_src[`BURST_W-1:`WORD_W];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cq_r <= 1'b0;
            cq_n_r <= 1'b1;
        end else if (k_rise) begin
            cq_r <= 1'b1;
            cq_n_r <= 1'b0;
        end else if (k_n_rise) begin
            cq_r <= 1'b0;
            cq_n_r <= 1'b1;
        end
    end

    assign dq_out = dq_r;
    assign dq_oe_n = ~valid_r;
    assign read_valid_flag = valid_r;
    assign cq = cq_r;
    assign cq_n = cq_n_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_addr_alternate: assert property (@(posedge clock) disable iff (!rst_n)
        cmd_take |=> second_r)
        else $error("taken address did not claim its second half");

    a_second_blocks: assert property (@(posedge clock) disable iff (!rst_n)
        (k_rise && second_r) |=> (!second_r && !pipe_v_r[0] && $stable(wr_addr_r)))
        else $error("command taken in second half of burst");

    a_write_take: assert property (@(posedge clock) disable iff (!rst_n)
        wr_take |=> (wr_pend_r && !wr_half_r && wr_addr_r == $past(pin_s2_r.addr)))
        else $error("write address not captured");

    a_write_pair: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_push && wr_ready) |=> pop_valid)
        else $error("write burst not buffered");

    a_burst_words: assert property (@(posedge clock) disable iff (!rst_n)
        lo_take |=> (wr_lo_r == $past(pin_s2_r.dq)))
        else $error("first write word not captured");

    a_read_fill: assert property (@(posedge clock) disable iff (!rst_n)
        rd_take |=> ##1 (pipe_d_r[0] == $past(mem_q)))
        else $error("array read not loaded into pipeline");

    a_launch_edge: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(read_valid_flag) |-> $past(any_edge))
        else $error("read data launched off an edge");

    a_slow_latency: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(valid_r) && byp_s2_r && $stable(byp_s2_r)) |-> pipe_v_r[5])
        else $error("read latency not 5 half cycles");

    a_fast_latency: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(valid_r) && !byp_s2_r && $stable(byp_s2_r)) |-> pipe_v_r[2])
        else $error("read latency not 2 half cycles");

    a_valid_pins: assert property (@(posedge clock) disable iff (!rst_n)
        (any_edge && (lo_hit || hi_hit)) |=> (read_valid_flag && !dq_oe_n))
        else $error("read word not flagged and driven");

    a_valid_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !any_edge |=> $stable(read_valid_flag))
        else $error("valid flag moved between edges");

    a_echo_rise: assert property (@(posedge clock) disable iff (!rst_n)
        k_rise |-> ##[1:ECHO_MAX] (cq && !cq_n))
        else $error("echo clock missed true rise");

    a_echo_fall: assert property (@(posedge clock) disable iff (!rst_n)
        k_n_rise |-> ##[1:ECHO_MAX] (!cq && cq_n))
        else $error("echo clock missed complementary rise");

    a_echo_out: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(cq) |-> $past(any_edge))
        else $error("echo clock moved between edges");

    a_bus_release: assert property (@(posedge clock) disable iff (!rst_n)
        (any_edge && !lo_hit && !hi_hit) |=> dq_oe_n)
        else $error("data bus not released");

    a_out_reg: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(dq_out) |-> $past(any_edge))
        else $error("data output changed between edges");

    a_self_write: assert property (@(posedge clock) disable iff (!rst_n)
        pop_valid |-> ##[0:DRAIN_MAX] drain)
        else $error("buffered write not drained");

endmodule : ddr_sram_top

/* include/sram_consts.svh */
// constants for the burst-of-two double data rate sram interface
// assumes a single system clock that oversamples the input clock pair
// Function
// - addresses are taken only on alternate rising edges of the true clock
// - write words are sampled on true and complementary clock rises
// - read words are launched on true and complementary clock rises
// - each address carries two data words as one burst
// - array holds one mega-burst of two 18-bit words
// - bypass pin high gives 2.5 cycle read latency
// - bypass pin low gives 1 cycle read latency
// - read valid flag marks edges carrying read data
// - echo clocks follow the edges that launch read data
// - read and write data use separate pin groups, dq_in for writes and dq_out for reads
// - every input and data output passes through a register
// - array writes are self timed inside the device
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

`define ADDR_W 20
`define WORD_W 18
`define BURST_W 36
`define LAT_PLL_EDGES 3'h5
`define LAT_DLL_EDGES 3'h2
`define PIPE_D 7
`define FIFO_D 8
`define SYNC_W 41

`endif

/* include/sram_pkg.sv */
// types shared by the sram interface files
// assumes sram_consts.svh is on the include path
`include "sram_consts.svh"

package sram_pkg;

    typedef struct packed {
        logic ld_n;
        logic rw;
        logic [`ADDR_W-1:0] addr;
        logic [`WORD_W-1:0] dq;
    } pin_in_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`BURST_W-1:0] data;
    } wr_burst_t;

endpackage : sram_pkg

/* rtl/burst_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active low reset
`timescale 1ns/10ps

module burst_fifo #(
    parameter int W = 56,
    parameter int D = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : burst_fifo

/* rtl/burst_mem.sv */
// burst array: one write port, one read port, registered read data
// assumes one clock; contents are undefined until written
`timescale 1ns/10ps

module burst_mem #(
    parameter int AW = 20,
    parameter int DW = 36
) (
    input wire logic clock,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] array_r [2**AW];

    always_ff @(posedge clock) begin
        if (we) begin
            array_r[waddr] <= wdata;
        end
        if (re) begin
            rdata <= array_r[raddr];
        end
    end

endmodule : burst_mem

/* tb/ctrl_model.sv */
// controller model: free running input clock pair, burst commands, write data
// assumes clock runs 8 times faster than the input clock pair
`timescale 1ns/10ps
`include "sram_consts.svh"

module ctrl_model (
    input wire logic clock,
    output logic k_clk,
    output logic k_clk_n,
    output logic ld_n,
    output logic rw,
    output logic [`ADDR_W-1:0] addr,
    output logic [`WORD_W-1:0] dq_in,
    output logic pll_bypass_pin
);
    typedef struct packed {
        logic rd;
        logic dbl;
        logic bp;
        logic [`ADDR_W-1:0] a;
        logic [`BURST_W-1:0] d;
    } cmd_t;
    cmd_t q[$];
    cmd_t cur;
    realtime rd_t[$];
    int ph = 0;
    int slot = 5;

    task automatic push(input logic rd, input logic dbl, input logic bp,
                        input logic [`ADDR_W-1:0] a, input logic [`BURST_W-1:0] d);
        q.push_back({rd, dbl, bp, a, d});
    endtask : push

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cur = '0;
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        ld_n = 1'b1;
        rw = 1'b0;
        addr = '0;
        dq_in = '0;
        pll_bypass_pin = 1'b1;
        forever begin
            @(negedge clock);
            ph = (ph + 1) % 8;
            k_clk = (ph < 4);
            k_clk_n = (ph >= 4);
            if (ph == 6) begin
                slot = slot + 1;
                if (slot == 1 && !cur.rd) dq_in = cur.d[`BURST_W-1:`WORD_W];
                if (slot >= 5 && q.size() > 0) begin
                    cur = q.pop_front();
                    slot = 0;
                    {ld_n, rw, addr, pll_bypass_pin} = {1'b0, cur.rd, cur.a, cur.bp};
                    if (cur.rd) rd_t.push_back($realtime);
                end
            end
            if (ph == 2 && slot == 0) begin
                // optional second low load on the following rise
                ld_n = !cur.dbl;
                addr = ~addr;
                if (!cur.rd) dq_in = cur.d[`WORD_W-1:0];
            end
            if (ph == 2 && slot == 1) begin
                ld_n = 1'b1;
                // released bus shows the inverse; next command waits 4 periods
                dq_in = ~dq_in;
            end
        end
    end
endmodule : ctrl_model

/* tb/testbench.sv */
// self-checking bench for the burst sram device interface
// assumes ctrl_model drives every pin but clock and rst_n; 40 ns clock, 320 ns input clock
`timescale 1ns/10ps
`include "sram_consts.svh"

module testbench;
    logic clock, rst_n, k_clk, k_clk_n, ld_n, rw, pll_bypass_pin, go;
    logic dq_oe_n, cq, cq_n, read_valid_flag, wr_ready;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] dq_in, dq_out;
    logic [`BURST_W-1:0] mem [8];
    logic [`BURST_W-1:0] exp_q[$];
    logic [`BURST_W-1:0] ev;
    int lat_q[$];
    int err_count = 0;
    int checked = 0;
    int vcnt = 0;
    int lat;
    realtime t0;

    ddr_sram_top i_ddr_sram_top (.clock(clock), .rst_n(rst_n), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .ld_n(ld_n), .rw(rw), .addr(addr), .dq_in(dq_in),
        .pll_bypass_pin(pll_bypass_pin), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .cq(cq),
        .cq_n(cq_n), .read_valid_flag(read_valid_flag), .wr_ready(wr_ready));
    ctrl_model i_ctrl_model (.clock(clock), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .ld_n(ld_n), .rw(rw), .addr(addr), .dq_in(dq_in), .pll_bypass_pin(pll_bypass_pin));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // ns from command issue to first valid sample
    function automatic int lat_ns(input logic bp);
        int e;
        e = bp ? `LAT_PLL_EDGES : `LAT_DLL_EDGES;
        return 45 + (4 + 4 * e) * 40;
    endfunction : lat_ns

    task automatic op(input logic rd, input logic dbl, input logic bp, input int i);
        logic [`BURST_W-1:0] d;
        d = {4'($urandom), $urandom};
        if (rd) begin
            exp_q.push_back(mem[i]);
            lat_q.push_back(lat_ns(bp));
        end else mem[i] = d;
        i_ctrl_model.push(rd, dbl, bp, {3'(i), {17{i[0]}}}, d);
    endtask : op

    ////////////////////////////////////////////////////////////////////////
    always begin
        @(negedge clock);
        #5;
        if (go && i_ctrl_model.ph == 6) chk(cq === 1'b1 && cq_n === 1'b0, "echo high");
        if (go && i_ctrl_model.ph == 2) chk(cq === 1'b0 && cq_n === 1'b1, "echo low");
        if (go) chk(dq_oe_n === ~read_valid_flag, "drive enable");
        if (go) chk(wr_ready === 1'b1, "write buffer room");
        if (read_valid_flag === 1'b1) vcnt++;
        else begin
            if (vcnt != 0) chk(vcnt == 8, "valid length");
            vcnt = 0;
        end
        if (vcnt == 1) begin
            if (exp_q.size() == 0) chk(1'b0, "unexpected burst");
            else begin
                ev = exp_q.pop_front();
                lat = lat_q.pop_front();
                t0 = i_ctrl_model.rd_t.pop_front();
                chk($realtime - t0 - lat < 21 && $realtime - t0 - lat > -21, "latency");
                chk(dq_out === ev[`WORD_W-1:0], "word0");
            end
        end
        if (vcnt == 5) chk(dq_out === ev[`BURST_W-1:`WORD_W], "word1");
    end

    initial begin
        rst_n = 1'b0;
        go = 1'b0;
        void'($urandom(32'h59F970B6));
        repeat (12) @(negedge clock);
        chk(dq_oe_n === 1'b1 && read_valid_flag === 1'b0 && cq === 1'b0 && cq_n === 1'b1
            && wr_ready === 1'b1, "reset values");
        rst_n = 1'b1;
        repeat (16) @(negedge clock);
        go = 1'b1;
        for (int i = 0; i < 8; i++) op(1'b0, 1'b0, 1'b1, i);
        op(1'b1, 1'b0, 1'b1, 7);
        op(1'b1, 1'b0, 1'b0, 0);
        op(1'b1, 1'b1, 1'b1, 3);
        op(1'b0, 1'b1, 1'b0, 5);
        op(1'b1, 1'b0, 1'b0, 5);
        $display("corner tests done");
        repeat (40) op(1'($urandom), $urandom % 4 == 0, 1'($urandom), $urandom % 8);
        while (i_ctrl_model.q.size() > 0) @(negedge clock);
        repeat (60) @(negedge clock);
        chk(exp_q.size() == 0, "reads outstanding");
        $display("random tests done");
        close_out();
    end

    initial begin
        repeat (8000) @(posedge clock);
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : testbench
